// [hw/lsc_sync_ctrl.sv]
// host controller that sets up and supervises multiframe clock alignment
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - write 0x03 to dual select first
// - mode codes one-shot, continuous, one-shot-then-monitor
// - window codes 0 to 3 only
// - enable sync after mode and window
// - arm in one-shot for next edge
// - send a reference pulse in subclass 1
// - subclass 0 or 1 only, both fields
// - both duals synchronised together
// - transmitter always sends alignment sequence
// - same multiframe delay to both links
// - same variation to both buffer delays
module lsc_sync_ctrl #(
  parameter int unsigned SPI_DIV = 4,
  parameter int unsigned POLL_LIMIT = 255
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic dev_sclk,
  output logic dev_cs_n,
  output logic dev_mosi,
  input wire logic dev_miso,
  output logic sysref_pulse,
  output logic tx_ilas_enable
);
  import lsc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_SYSREF = 3'b011,
    ST_POLL = 3'b100,
    ST_POLL_WAIT = 3'b101
  } lsc_state_t;

  typedef enum logic [1:0] {
    SEQ_START = 2'b00,
    SEQ_STICKY = 2'b01,
    SEQ_IRQ = 2'b10
  } lsc_seq_t;

  lsc_state_t state_q;
  lsc_seq_t seq_q;
  logic [3:0] step_q;
  lsc_cfg_t cfg_q;
  logic [7:0] min_delay_q;
  logic [7:0] variation_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic done_q;
  logic err_q;
  logic timeout_q;
  logic enabled_q;
  logic sysref_q;
  logic [7:0] dev_status_q;
  logic [3:0] irq_a_q;
  logic [3:0] irq_b_q;
  logic [7:0] irq_byte_q;
  logic [7:0] poll_cnt_q;

  logic ahb_go;
  logic wr_cmd;
  logic cmd_start;
  logic cmd_sticky;
  logic cmd_irq;
  logic idle;
  logic cfg_ok;
  logic [2:0] frames_per_proc_cycle;
  logic [9:0] mf_product;
  logic [7:0] min_less_one;
  logic [7:0] multiframe_delay;
  logic [7:0] ctrl_base;
  lsc_spi_req_t op;
  logic op_last;
  logic spi_start;
  logic spi_done;
  logic [7:0] spi_rdata;
  logic lane_err_unreported;

  // ------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, read data registered at address phase
  // ------------------------------------------------------------------------
  assign ahb_go = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;
  assign wr_cmd = wr_pend_q && (wr_addr_q == LSC_REG_CMD);
  assign idle = (state_q == ST_IDLE);
  assign cmd_start = wr_cmd && hwdata[LSC_CMD_START] && idle;
  assign cmd_sticky = wr_cmd && hwdata[LSC_CMD_CLRSTKY] && idle;
  assign cmd_irq = wr_cmd && hwdata[LSC_CMD_IRQSVC] && idle;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= ahb_go && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  // configuration is frozen while a sequence runs, so it cannot tear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= LSC_CFG_RESET;
      min_delay_q <= LSC_DELAY_RESET[7:0];
      variation_q <= LSC_DELAY_RESET[15:8];
    end else if (wr_pend_q && idle) begin
      if (wr_addr_q == LSC_REG_CFG) begin
        cfg_q <= hwdata;
      end
      if (wr_addr_q == LSC_REG_DELAY) begin
        min_delay_q <= hwdata[7:0];
        variation_q <= hwdata[15:8];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (ahb_go && !hwrite) begin
      case (haddr[7:0])
        LSC_REG_CFG: hrdata_q <= cfg_q;
        LSC_REG_DELAY: hrdata_q <= {13'h0000, frames_per_proc_cycle,
                                    variation_q, min_delay_q};
        LSC_REG_STATUS: hrdata_q <= {multiframe_delay, irq_b_q, irq_a_q,
                                     dev_status_q, 3'h0, lane_err_unreported,
                                     timeout_q, err_q, done_q, !idle};
        default: hrdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------------------
  // derived link settings
  // ------------------------------------------------------------------------
  always_comb begin
    case (cfg_q.octets_f)
      3'h1: frames_per_proc_cycle = LSC_OCTETS_PER_PCLK;
      3'h2: frames_per_proc_cycle = 3'h2;
      default: frames_per_proc_cycle = 3'h1;
    endcase
  end

  // K is a power of two, so the modulo is a mask of K-1
  assign min_less_one = (min_delay_q == 8'h00) ? 8'h00 : min_delay_q - 8'h01;
  assign mf_product = 10'(min_less_one * frames_per_proc_cycle);
  assign multiframe_delay = mf_product[7:0] &
                            {2'h0, cfg_q.frames_k - 6'h01};

  assign lane_err_unreported = (cfg_q.subclass == LSC_SUBCLASS0) &&
                               (cfg_q.octets_f == 3'h1);
  assign tx_ilas_enable = 1'b1;

  always_comb begin
    cfg_ok = 1'b1;
    if ((cfg_q.align_mode_select != LSC_MODE_ONESHOT) &&
        (cfg_q.align_mode_select != LSC_MODE_CONT) &&
        (cfg_q.align_mode_select != LSC_MODE_MONITOR)) begin
      cfg_ok = 1'b0;
    end
    if (cfg_q.phase_tolerance > LSC_WIN_MAX) begin
      cfg_ok = 1'b0;
    end
    if ((cfg_q.subclass != LSC_SUBCLASS0) &&
        (cfg_q.subclass != LSC_SUBCLASS1)) begin
      cfg_ok = 1'b0;
    end
    if ((cfg_q.octets_f != 3'h1) && (cfg_q.octets_f != 3'h2) &&
        (cfg_q.octets_f != 3'h4)) begin
      cfg_ok = 1'b0;
    end
    if ((cfg_q.frames_k != 6'h10) && (cfg_q.frames_k != 6'h20)) begin
      cfg_ok = 1'b0;
    end
    if (variation_q > LSC_RBD_MAX) begin
      cfg_ok = 1'b0;
    end
  end

  // ------------------------------------------------------------------------
  // device access sequences, one serial write or read per step
  // ------------------------------------------------------------------------
  assign ctrl_base = {4'h0, cfg_q.align_mode_select};

  always_comb begin
    op = '{write: 1'b1, addr: LSC_DEV_SYNC_STAT, data: 8'h00};
    op_last = 1'b0;
    case (seq_q)
      SEQ_START: begin
        case (step_q)
          4'h0: op = '{1'b1, LSC_DEV_DUAL_SEL, LSC_DUAL_BOTH};
          4'h1: op = '{1'b1, LSC_DEV_ERR_WIN,
                       {5'h00, cfg_q.phase_tolerance}};
          4'h2: op = '{1'b1, LSC_DEV_SYNC_CTRL, ctrl_base};
          4'h3: op = '{1'b1, LSC_DEV_GSUBCLASS,
                       {5'h00, cfg_q.subclass}};
          4'h4: op = '{1'b1, LSC_DEV_LSUBCLASS,
                       {cfg_q.subclass, 5'h00}};
          4'h5: op = '{1'b1, LSC_DEV_MF_DEL0, multiframe_delay};
          4'h6: op = '{1'b1, LSC_DEV_MF_DEL1, multiframe_delay};
          4'h7: op = '{1'b1, LSC_DEV_RBD0, variation_q};
          4'h8: op = '{1'b1, LSC_DEV_RBD1, variation_q};
          4'h9: op = '{1'b1, LSC_DEV_IRQ_EN_A, {4'h0, cfg_q.irq_a}};
          4'hA: op = '{1'b1, LSC_DEV_IRQ_EN_B, {4'h0, cfg_q.irq_b}};
          4'hB: begin
            op = '{1'b1, LSC_DEV_SYNC_CTRL,
                   ctrl_base | (8'h01 << LSC_CTRL_ENABLE)};
            // continuous mode needs no arming
            op_last = (cfg_q.align_mode_select == LSC_MODE_CONT);
          end
          default: begin
            // one-shot and monitor modes align on the first edge after arming
            op = '{1'b1, LSC_DEV_SYNC_CTRL,
                   ctrl_base | (8'h01 << LSC_CTRL_ENABLE) |
                   (8'h01 << LSC_CTRL_ARM)};
            op_last = 1'b1;
          end
        endcase
      end
      SEQ_STICKY: begin
        op = '{1'b1, LSC_DEV_SYNC_CTRL,
               ctrl_base | ({7'h00, enabled_q} << LSC_CTRL_ENABLE) |
               (8'h01 << LSC_CTRL_CLRSTKY)};
        op_last = 1'b1;
      end
      default: begin
        // read each status byte, then write the same ones back to clear
        case (step_q)
          4'h0: op = '{1'b0, LSC_DEV_IRQ_ST_A, 8'h00};
          4'h1: op = '{1'b1, LSC_DEV_IRQ_ST_A, irq_byte_q};
          4'h2: op = '{1'b0, LSC_DEV_IRQ_ST_B, 8'h00};
          default: begin
            op = '{1'b1, LSC_DEV_IRQ_ST_B, irq_byte_q};
            op_last = 1'b1;
          end
        endcase
      end
    endcase
    // a poll reads status whatever step the sequence ended on
    if (state_q == ST_POLL) begin
      op = '{1'b0, LSC_DEV_SYNC_STAT, 8'h00};
    end
  end

  // ------------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------------
  assign spi_start = (state_q == ST_ISSUE) || (state_q == ST_POLL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      seq_q <= SEQ_START;
      step_q <= 4'h0;
      poll_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          step_q <= 4'h0;
          poll_cnt_q <= 8'h00;
          if (cmd_start && cfg_ok) begin
            seq_q <= SEQ_START;
            state_q <= ST_ISSUE;
          end else if (cmd_sticky) begin
            seq_q <= SEQ_STICKY;
            state_q <= ST_ISSUE;
          end else if (cmd_irq) begin
            seq_q <= SEQ_IRQ;
            state_q <= ST_ISSUE;
          end
        end
        ST_ISSUE: state_q <= ST_WAIT;
        ST_WAIT: begin
          if (spi_done) begin
            step_q <= step_q + 4'h1;
            if (!op_last) begin
              state_q <= ST_ISSUE;
            end else if (seq_q != SEQ_START) begin
              state_q <= ST_IDLE;
            end else if (cfg_q.subclass == LSC_SUBCLASS1) begin
              state_q <= ST_SYSREF;
            end else begin
              state_q <= ST_POLL;
            end
          end
        end
        ST_SYSREF: state_q <= ST_POLL;
        ST_POLL: state_q <= ST_POLL_WAIT;
        ST_POLL_WAIT: begin
          if (spi_done) begin
            poll_cnt_q <= poll_cnt_q + 8'h01;
            if (spi_rdata[LSC_STAT_BUSY] &&
                (poll_cnt_q < 8'(POLL_LIMIT - 1))) begin
              state_q <= ST_POLL;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= (state_q == ST_SYSREF);
    end
  end
  assign sysref_pulse = sysref_q;

  // ------------------------------------------------------------------------
  // status captured from the device
  // ------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dev_status_q <= 8'h00;
      timeout_q <= 1'b0;
    end else if (cmd_start) begin
      timeout_q <= 1'b0;
    end else if ((state_q == ST_POLL_WAIT) && spi_done) begin
      // lock, rotation, window-limit and trip bits as the device reports them
      dev_status_q <= spi_rdata;
      timeout_q <= spi_rdata[LSC_STAT_BUSY] &&
                   (poll_cnt_q >= 8'(POLL_LIMIT - 1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_byte_q <= 8'h00;
      irq_a_q <= 4'h0;
      irq_b_q <= 4'h0;
    end else if ((state_q == ST_WAIT) && spi_done && (seq_q == SEQ_IRQ)) begin
      if (step_q == 4'h0) begin
        irq_byte_q <= {4'h0, spi_rdata[3:0]};
        irq_a_q <= spi_rdata[3:0];
      end
      if (step_q == 4'h2) begin
        irq_byte_q <= {4'h0, spi_rdata[3:0]};
        irq_b_q <= spi_rdata[3:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else if (cmd_start) begin
      done_q <= 1'b0;
      err_q <= !cfg_ok;
    end else if ((state_q == ST_POLL_WAIT) && spi_done &&
                 (!spi_rdata[LSC_STAT_BUSY] ||
                  (poll_cnt_q >= 8'(POLL_LIMIT - 1)))) begin
      done_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enabled_q <= 1'b0;
    end else if ((state_q == ST_WAIT) && spi_done && (seq_q == SEQ_START) &&
                 (step_q == 4'hB)) begin
      enabled_q <= 1'b1;
    end
  end

  lsc_spi_master #(
    .DIV(SPI_DIV)
  ) u_spi (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(spi_start),
    .req(op),
    .busy(),
    .done(spi_done),
    .rdata(spi_rdata),
    .sclk(dev_sclk),
    .cs_n(dev_cs_n),
    .mosi(dev_mosi),
    .miso(dev_miso)
  );

endmodule : lsc_sync_ctrl

`default_nettype wire

// [hw/lsc_pkg.sv]
// package of constants and carriers for the multiframe clock sync controller
package lsc_pkg;

  // ------------------------------------------------------------------------
  // device register offsets, reached over the device's serial port
  // ------------------------------------------------------------------------
  localparam logic [14:0] LSC_DEV_DUAL_SEL = 15'h0008;
  localparam logic [14:0] LSC_DEV_IRQ_EN_A = 15'h0021;
  localparam logic [14:0] LSC_DEV_IRQ_EN_B = 15'h0022;
  localparam logic [14:0] LSC_DEV_IRQ_ST_A = 15'h0025;
  localparam logic [14:0] LSC_DEV_IRQ_ST_B = 15'h0026;
  localparam logic [14:0] LSC_DEV_ERR_WIN = 15'h0034;
  localparam logic [14:0] LSC_DEV_SYNC_CTRL = 15'h003A;
  localparam logic [14:0] LSC_DEV_SYNC_STAT = 15'h003B;
  localparam logic [14:0] LSC_DEV_GSUBCLASS = 15'h0301;
  localparam logic [14:0] LSC_DEV_MF_DEL0 = 15'h0304;
  localparam logic [14:0] LSC_DEV_MF_DEL1 = 15'h0305;
  localparam logic [14:0] LSC_DEV_RBD0 = 15'h0306;
  localparam logic [14:0] LSC_DEV_RBD1 = 15'h0307;
  localparam logic [14:0] LSC_DEV_LSUBCLASS = 15'h0458;

  // ------------------------------------------------------------------------
  // device field values and bit positions
  // ------------------------------------------------------------------------
  localparam logic [7:0] LSC_DUAL_BOTH = 8'h03;
  localparam logic [3:0] LSC_MODE_ONESHOT = 4'h1;
  localparam logic [3:0] LSC_MODE_CONT = 4'h2;
  localparam logic [3:0] LSC_MODE_MONITOR = 4'h9;
  localparam logic [2:0] LSC_WIN_MAX = 3'h3;
  localparam int LSC_CTRL_ENABLE = 7;
  localparam int LSC_CTRL_ARM = 6;
  localparam int LSC_CTRL_CLRSTKY = 5;
  localparam int LSC_STAT_BUSY = 7;
  localparam int LSC_LSUB_LSB = 5;
  localparam logic [2:0] LSC_SUBCLASS0 = 3'h0;
  localparam logic [2:0] LSC_SUBCLASS1 = 3'h1;
  localparam logic [7:0] LSC_RBD_MAX = 8'h0A;
  localparam logic [2:0] LSC_OCTETS_PER_PCLK = 3'h4;

  // ------------------------------------------------------------------------
  // controller's own register map on the AHB-Lite side
  // ------------------------------------------------------------------------
  localparam logic [7:0] LSC_REG_CMD = 8'h00;
  localparam logic [7:0] LSC_REG_CFG = 8'h04;
  localparam logic [7:0] LSC_REG_DELAY = 8'h08;
  localparam logic [7:0] LSC_REG_STATUS = 8'h0C;
  localparam int LSC_CMD_START = 0;
  localparam int LSC_CMD_CLRSTKY = 1;
  localparam int LSC_CMD_IRQSVC = 2;
  localparam logic [31:0] LSC_CFG_RESET = 32'h0010_2101;
  localparam logic [15:0] LSC_DELAY_RESET = 16'h0000;

  // ------------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------------
  typedef struct packed {
    logic [3:0] irq_b;
    logic [3:0] irq_a;
    logic [1:0] rsv2;
    logic [5:0] frames_k;
    logic rsv1;
    logic [2:0] octets_f;
    logic rsv0;
    logic [2:0] subclass;
    logic rsvw;
    logic [2:0] phase_tolerance;
    logic [3:0] align_mode_select;
  } lsc_cfg_t;

  typedef struct packed {
    logic write;
    logic [14:0] addr;
    logic [7:0] data;
  } lsc_spi_req_t;

endpackage : lsc_pkg

// [hw/lsc_spi_master.sv]
// serial port master that moves one 24-bit device register access
`timescale 1ns/100ps
`default_nettype none

module lsc_spi_master #(
  parameter int unsigned DIV = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire lsc_pkg::lsc_spi_req_t req,
  output logic busy,
  output logic done,
  output logic [7:0] rdata,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  import lsc_pkg::*;

  logic act_q;
  logic [23:0] sh_q;
  logic [7:0] rx_q;
  logic [4:0] cnt_q;
  logic [7:0] div_q;
  logic sclk_q;
  logic done_q;
  logic [7:0] rdata_q;
  logic tick;

  assign tick = act_q && (div_q == 8'(DIV - 1));
  assign busy = act_q;
  assign done = done_q;
  assign rdata = rdata_q;
  assign sclk = sclk_q;
  assign cs_n = !act_q;
  assign mosi = sh_q[23];

  // ------------------------------------------------------------------------
  // frame shifter: data out changes on falling, data in taken on rising
  // ------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q <= 1'b0;
      sh_q <= 24'h00_0000;
      cnt_q <= 5'h00;
      sclk_q <= 1'b0;
    end else if (start && !act_q) begin
      act_q <= 1'b1;
      sh_q <= {!req.write, req.addr, req.data};
      cnt_q <= 5'h18;
      sclk_q <= 1'b0;
    end else if (tick) begin
      sclk_q <= !sclk_q;
      if (sclk_q) begin
        sh_q <= {sh_q[22:0], 1'b0};
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          act_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= 8'h00;
    end else if (!act_q || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q <= 8'h00;
    end else if (tick && !sclk_q) begin
      rx_q <= {rx_q[6:0], miso};
    end
  end

  // last falling edge of the frame closes it and hands back the data byte
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      done_q <= tick && sclk_q && (cnt_q == 5'h01);
      if (tick && sclk_q && (cnt_q == 5'h01)) begin
        rdata_q <= rx_q;
      end
    end
  end

endmodule : lsc_spi_master

`default_nettype wire

// [verification/lsc_sync_ctrl_properties.sv]
// checker of bus and serial-port timing for the sync controller
`timescale 1ns/100ps
`default_nettype none

module lsc_sync_ctrl_properties #(
  parameter int unsigned SPI_DIV = 4,
  parameter int unsigned POLL_LIMIT = 255
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic dev_sclk,
  input wire logic dev_cs_n,
  input wire logic dev_mosi,
  input wire logic sysref_pulse,
  input wire logic tx_ilas_enable
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // rising serial clock edges seen in the current frame
  logic [4:0] rises_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rises_q <= 5'h00;
    end else begin
      rises_q <= dev_cs_n ? 5'h00 : rises_q + 5'($rose(dev_sclk));
    end
  end

  // high phase lasts SPI_DIV cycles; literal matches the bench's setting
  sequence s_sclk_high;
    dev_sclk [*4] ##1 !dev_sclk;
  endsequence
  sequence s_rd_unmapped;
    hsel && hready && htrans[1] && !hwrite &&
      !(haddr[7:0] inside {8'h00, 8'h04, 8'h08, 8'h0C});
  endsequence

  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_ready_no_wait: assert property (hreadyout == 1'b1)
    else $error("wait state inserted");
  chk_ilas_always_on: assert property (tx_ilas_enable)
    else $error("lane alignment sequence request dropped");
  chk_sysref_single: assert property (sysref_pulse |=> !sysref_pulse)
    else $error("reference pulse longer than one cycle");
  chk_sclk_idle_low: assert property (dev_cs_n |-> !dev_sclk)
    else $error("serial clock active outside frame");
  chk_sclk_half: assert property ($rose(dev_sclk) |-> s_sclk_high)
    else $error("serial clock high phase wrong");
  chk_mosi_stable: assert property ($rose(dev_sclk) |-> $stable(dev_mosi))
    else $error("serial data moved at clock rise");
  chk_frame_bits: assert property ($rose(dev_cs_n) |-> rises_q == 5'd24)
    else $error("frame not 24 bits");
  chk_frame_gap: assert property ($rose(dev_cs_n) |-> dev_cs_n [*2])
    else $error("frames too close");
  chk_rd_unmapped: assert property (s_rd_unmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : lsc_sync_ctrl_properties

bind lsc_sync_ctrl lsc_sync_ctrl_properties #(
  .SPI_DIV(SPI_DIV),
  .POLL_LIMIT(POLL_LIMIT)
) u_chk (.*);

`default_nettype wire

// [verification/lsc_dev_model.sv]
// behavioural model of the converter's sync registers behind its serial port
`timescale 1ns/100ps
`default_nettype none

module lsc_dev_model (
  input wire logic hclk,
  input wire logic dev_sclk,
  input wire logic dev_cs_n,
  input wire logic dev_mosi,
  output logic dev_miso,
  input wire logic sysref_pulse,
  input wire logic hold_busy
);
  logic [7:0] mem [0:2047];
  logic [23:0] sh = 24'h0;
  logic [7:0] rd = 8'h0;
  logic busy_q = 1'b0, lock_q = 1'b0, rot_q = 1'b0, trip_q = 1'b0;
  int cnt = 0;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    dev_miso = 1'b0;
  end

  function automatic logic [7:0] peek(logic [14:0] a);
    logic [7:0] st;
    st = {busy_q, 3'h0, lock_q, rot_q, 1'b0, trip_q};
    case (a)
      15'h003B: return st;
      15'h0025: return {4'h0, st[3:0]} & mem[11'h021];
      15'h0026: return {4'h0, st[3:0]} & mem[11'h022];
      default: return mem[a[10:0]];
    endcase
  endfunction : peek

  task automatic align;
    busy_q = 1'b0;
    rot_q = rot_q | !lock_q;
    lock_q = 1'b1;
    trip_q = 1'b1;
  endtask : align

  always @(negedge dev_cs_n) cnt = 0;
  always @(posedge dev_sclk) begin
    sh = {sh[22:0], dev_mosi};
    cnt++;
    if (cnt == 16) rd = peek(sh[14:0]);
  end
  always @(negedge dev_sclk) begin
    if (cnt >= 16 && cnt < 24) dev_miso = rd[23 - cnt];
  end
  // released line shows the inverse so a stale bit is never read as valid
  always @(posedge dev_cs_n) begin
    dev_miso = ~dev_miso;
    if (cnt == 24 && !sh[23]) begin
      if (!(sh[22:8] inside {15'h0025, 15'h0026})) mem[sh[18:8]] = sh[7:0];
      if (sh[22:8] == 15'h003A && sh[5]) {rot_q, trip_q} = 2'b00;
      if (sh[22:8] == 15'h003A && sh[7] && !sh[5]) busy_q = 1'b1;
    end
    // without reference pulses the internal clock edge aligns on a poll
    if (cnt == 24 && sh[23] && sh[22:8] == 15'h003B && busy_q && !hold_busy &&
        mem[11'h301][2:0] == 3'h0) align();
  end
  always @(posedge hclk) begin
    if (sysref_pulse && busy_q && !hold_busy) align();
  end
endmodule : lsc_dev_model

`default_nettype wire

// [verification/lsc_sync_ctrl_tb.sv]
// self-checking bench for the multiframe clock sync controller
`timescale 1ns/100ps
`default_nettype none

module lsc_sync_ctrl_tb;
  import lsc_pkg::*;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
  logic hold_busy = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, s, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, dev_sclk, dev_cs_n, dev_mosi, dev_miso;
  logic sysref_pulse, tx_ilas_enable;
  int n_mismatch = 0, n_checks = 0, nsr = 0, base = 0;
  logic [3:0] modes [3] = '{LSC_MODE_ONESHOT, LSC_MODE_CONT, LSC_MODE_MONITOR};

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (sysref_pulse === 1'b1) nsr++;

  lsc_sync_ctrl #(.SPI_DIV(4), .POLL_LIMIT(4)) dut (.*);
  lsc_dev_model dev (.*);

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  function automatic logic [7:0] m(int a);
    return dev.mem[a];
  endfunction : m

  function automatic logic [31:0] cfg(logic [3:0] md, logic [2:0] w, sb, f,
                                     logic [5:0] k);
    return {4'h9, 4'hF, 2'h0, k, 1'b0, f, 1'b0, sb, 1'b0, w, md};
  endfunction : cfg

  function automatic logic [31:0] mfd(int mn, f, k);
    return (mn == 0) ? 32'h0 : 32'(((mn - 1) * (4 / f)) % k);
  endfunction : mfd

  // one idle cycle first: a poll in the write's data phase may miss busy
  task automatic poll(input logic [31:0] cmd);
    base = nsr;
    xfer(LSC_REG_CMD, 1'b1, cmd);
    @(posedge hclk);
    for (int i = 0; i < 3000; i++) begin
      xfer(LSC_REG_STATUS, 1'b0, 32'h0);
      s = r;
      if (s[0] === 1'b0) break;
    end
  endtask : poll

  task automatic run(input logic [31:0] c, input logic [7:0] mn, vr);
    xfer(LSC_REG_CFG, 1'b1, c);
    xfer(LSC_REG_DELAY, 1'b1, {16'h0, vr, mn});
    poll(32'h1);
  endtask : run

  initial begin
    logic [7:0] mn, vr;
    logic [3:0] md;
    logic [2:0] w, f;
    logic [5:0] k;
    void'($urandom(32'hF062B855));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(LSC_REG_CFG, 1'b0, 32'h0);
    chk("cfg reset", r, LSC_CFG_RESET);
    xfer(LSC_REG_DELAY, 1'b0, 32'h0);
    chk("delay reset", r, {13'h0, 3'(4 / LSC_CFG_RESET[14:12]), 16'h0});
    xfer(8'h10, 1'b1, 32'hFFFF_FFFF);
    xfer(8'h10, 1'b0, 32'h0);
    chk("unmapped", r, 32'h0);
    for (int i = 0; i < 6; i++) begin
      md = modes[i % 3];
      w = 3'($urandom % 4);
      f = 3'(1 << (i / 2));
      k = (f == 3'h1 || $urandom % 2) ? 6'd32 : 6'd16;
      mn = (i == 1) ? 8'h00 : 8'($urandom % 40);
      vr = (i == 0) ? LSC_RBD_MAX : 8'($urandom % 11);
      run(cfg(md, w, LSC_SUBCLASS1, f, k), mn, vr);
      chk("done", 32'(s[2:1]), 32'h1);
      chk("dev status", 32'(s[15:8] & 8'h8B), 32'h09);
      chk("mf delay", 32'(s[31:24]), mfd(mn, f, k));
      chk("del0", 32'(m(12'h304)), mfd(mn, f, k));
      chk("del1", 32'(m(12'h305)), mfd(mn, f, k));
      chk("var0", 32'(m(12'h306)), 32'(vr));
      chk("var1", 32'(m(12'h307)), 32'(vr));
      chk("dual", 32'(m(12'h008)), 32'(LSC_DUAL_BOTH));
      chk("window", 32'(m(12'h034)), 32'(w));
      r = 32'(m(12'h03A));
      chk("mode", r & 32'h8F, {24'h0, 4'h8, md});
      chk("arm", 32'(r[6]), 32'(md != LSC_MODE_CONT));
      chk("subclass", {m(12'h301), m(12'h458)}, 32'h0120);
      chk("sysref", 32'(nsr - base), 32'h1);
      xfer(LSC_REG_DELAY, 1'b0, 32'h0);
      chk("delay rd", r, {13'h0, 3'(4 / f), vr, mn});
    end
    run(cfg(LSC_MODE_ONESHOT, 3'h0, LSC_SUBCLASS0, 3'h1, 6'd32), 8'd5, 8'd3);
    chk("sc0 ref", 32'(nsr - base), 32'h0);
    chk("sc0 lane", 32'(s[4]), 32'h1);
    chk("sc0 sub", {m(12'h301), m(12'h458), m(12'h008)}, 32'h03);
    chk("irq en", {m(12'h021), m(12'h022)}, 32'h0F09);
    poll(32'h2);
    chk("clear", {dev.mem[12'h03A][5], dev.rot_q, dev.trip_q}, 32'h4);
    poll(32'h4);
    chk("irq a", 32'(s[19:16]), 32'h8);
    chk("irq b", 32'(s[23:20]), 32'h8);
    for (int j = 0; j < 3; j++) begin
      run(cfg((j == 0) ? 4'h3 : 4'h1, (j == 1) ? 3'h5 : 3'h0,
              (j == 2) ? 3'h2 : 3'h1, 3'h1, 6'd32), 8'd1, 8'd1);
      chk("bad cfg", 32'(s[2]), 32'h1);
      chk("bad ref", 32'(nsr - base), 32'h0);
    end
    hold_busy <= 1'b1;
    run(cfg(LSC_MODE_CONT, 3'h1, LSC_SUBCLASS1, 3'h2, 6'd16), 8'd4, 8'd2);
    chk("poll limit", 32'(s[3]), 32'h1);
    test_done();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    n_mismatch++;
    test_done();
  end
endmodule : lsc_sync_ctrl_tb

`default_nettype wire
